// *** design/xbar_out4_pkg.sv ***
// Overview of operation
// - each 2-bit selector code 00..11 picks candidate input zero..three.
// - low word at index Ch holds selectors 0..15, selector n in bits 2n+1:2n.
// - high word at index Eh holds selectors 16..31, selector 16 in bits 1:0.
// - all fields read/write by software; reset clears every field to zero.
// - all 32 selectors serve crossbar output four only.
package xbar_out4_pkg;

   // =====================================================
   // register map (printed offsets are word indices)
   localparam int unsigned   SEL_LOW_INDEX   = 32'h0000_000c;
   localparam int unsigned   SEL_HIGH_INDEX  = 32'h0000_000e;
   localparam logic [7:0]    SEL_LOW_ADDR    = 8'(SEL_LOW_INDEX * 4);
   localparam logic [7:0]    SEL_HIGH_ADDR   = 8'(SEL_HIGH_INDEX * 4);
   localparam int unsigned   ADDR_W          = 8;

   // =====================================================
   // field layout and reset values
   localparam int unsigned   SEL_COUNT       = 32;
   localparam int unsigned   SEL_PER_WORD    = 16;
   localparam int unsigned   SEL_W           = 2;
   localparam int unsigned   CAND_COUNT      = 4;
   localparam logic [31:0]   SEL_WORD_RESET  = 32'h0000_0000;
   localparam logic [31:0]   UNMAPPED_RDATA  = 32'h0000_0000;

   // =====================================================
   // apb request carrier
   typedef struct packed {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [31:0]       pwdata;
   } apb_req_s;

   typedef struct packed {
      logic              pready;
      logic              pslverr;
      logic [31:0]       prdata;
   } apb_rsp_s;

endpackage : xbar_out4_pkg

// *** design/crossbar_output_select_regs.sv ***
`timescale 1ns/100ps
module crossbar_output_select_regs
   import xbar_out4_pkg::*;
(
   // clock and reset
   input  wire logic                             clk_sys,
   input  wire logic                             nrst,
   // apb slave
   input  wire apb_req_s                         apb_req,
   output      apb_rsp_s                         apb_rsp,
   // candidate inputs, four per selector
   input  wire logic [SEL_COUNT-1:0][CAND_COUNT-1:0] cand_in,
   // selected signals towards the combining logic of crossbar output four
   output      logic [SEL_COUNT-1:0]             crossbar_output_four
);

   // =====================================================
   // selector registers
   logic [31:0] sel_low_r;
   logic [31:0] sel_high_r;
   logic        wr_acc;
   logic        rd_acc;
   logic [31:0] rdata_nxt;
   logic [31:0] rdata_r;
   logic        err_nxt;
   logic        err_r;
   logic        hit_low;
   logic        hit_high;

   // setup phase with no wait state: pready is high in every access phase
   assign hit_low  = (apb_req.paddr == SEL_LOW_ADDR);
   assign hit_high = (apb_req.paddr == SEL_HIGH_ADDR);
   assign wr_acc   = apb_req.psel & apb_req.penable & apb_req.pwrite;
   assign rd_acc   = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         sel_low_r <= SEL_WORD_RESET;
      end
      else if (wr_acc && hit_low)
      begin
         sel_low_r <= apb_req.pwdata;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         sel_high_r <= SEL_WORD_RESET;
      end
      else if (wr_acc && hit_high)
      begin
         sel_high_r <= apb_req.pwdata;
      end
   end

   // =====================================================
   // read path: data captured in setup so prdata comes from a flop
   always_comb
   begin
      rdata_nxt = UNMAPPED_RDATA;
      err_nxt   = 1'b1;
      if (hit_low)
      begin
         rdata_nxt = sel_low_r;
         err_nxt   = 1'b0;
      end
      else if (hit_high)
      begin
         rdata_nxt = sel_high_r;
         err_nxt   = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         rdata_r <= 32'h0000_0000;
         err_r   <= 1'b0;
      end
      else if (apb_req.psel && !apb_req.penable)
      begin
         rdata_r <= rd_acc ? rdata_nxt : 32'h0000_0000;
         err_r   <= err_nxt;
      end
   end

   // unmapped addresses answer with pslverr and zero data; writes to them are dropped
   assign apb_rsp.pready  = 1'b1;
   assign apb_rsp.pslverr = apb_req.psel & apb_req.penable & err_r;
   assign apb_rsp.prdata  = rdata_r;

   // =====================================================
   // one four-way mux per selector, all feeding output four only
   genvar gi;
   generate
      for (gi = 0; gi < SEL_COUNT; gi++)
      begin : g_sel
         logic [SEL_W-1:0] code;
         if (gi < SEL_PER_WORD)
         begin : g_lo
            assign code = sel_low_r[SEL_W*gi +: SEL_W];
         end
         else
         begin : g_hi
            assign code = sel_high_r[SEL_W*(gi-SEL_PER_WORD) +: SEL_W];
         end
         // combinational so the selected input follows live; the code itself is registered
         assign crossbar_output_four[gi] = cand_in[gi][code];
      end
   endgenerate

endmodule : crossbar_output_select_regs

// *** dv/xbar_out4_props.sv ***
`timescale 1ns/100ps
module xbar_out4_props
   import xbar_out4_pkg::*;
(
   // watched ports
   input wire logic                                 clk_sys,
   input wire logic                                 nrst,
   input wire apb_req_s                             apb_req,
   input wire apb_rsp_s                             apb_rsp,
   input wire logic [SEL_COUNT-1:0][CAND_COUNT-1:0] cand_in,
   input wire logic [SEL_COUNT-1:0]                 crossbar_output_four
);
   // =====================================================
   // bus and routing checks
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   wire acc = apb_req.psel && apb_req.penable;
   wire hit = apb_req.paddr == SEL_LOW_ADDR || apb_req.paddr == SEL_HIGH_ADDR;
   property p_ready; acc |-> apb_rsp.pready; endproperty
   a_ready: assert property (p_ready) else $error("access without ready");
   property p_err; acc && !hit |-> apb_rsp.pslverr && apb_rsp.prdata == UNMAPPED_RDATA; endproperty
   a_err: assert property (p_err) else $error("unmapped access accepted");
   property p_ok; acc && hit |-> !apb_rsp.pslverr; endproperty
   a_ok: assert property (p_ok) else $error("mapped access refused");
   // outputs may only move on a write or a candidate change
   property p_hold; !(acc && apb_req.pwrite) ##1 $stable(cand_in) |-> $stable(crossbar_output_four); endproperty
   a_hold: assert property (p_hold) else $error("output moved without cause");
   // read data stands through the cycle after its access phase
   property p_rhold; acc |=> $stable(apb_rsp.prdata); endproperty
   a_rhold: assert property (p_rhold) else $error("read data moved after access");
   property p_idle; !acc |-> !apb_rsp.pslverr; endproperty
   a_idle: assert property (p_idle) else $error("error flagged outside access");
endmodule : xbar_out4_props

// *** dv/testbench.sv ***
`timescale 1ns/100ps
module testbench import xbar_out4_pkg::*;;
   // =====================================================
   // stimulus and checks
   logic clk_sys = 0;
   logic nrst = 0;
   apb_req_s req = '0;
   apb_rsp_s rsp;
   logic [SEL_COUNT-1:0][CAND_COUNT-1:0] cand = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;
   logic [SEL_COUNT-1:0] out;
   logic [31:0] rd;
   logic er;
   int fails = 0;
   int checks = 0;
   always #5 clk_sys = ~clk_sys;
   crossbar_output_select_regs dut (.clk_sys(clk_sys), .nrst(nrst), .apb_req(req), .apb_rsp(rsp),
      .cand_in(cand), .crossbar_output_four(out));
   task summarize;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : summarize
   task chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e)
      begin
         fails++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   function logic [31:0] mux(input logic [31:0] lo, input logic [31:0] hi);
      logic [63:0] w;
      w = {hi, lo};
      for (int n = 0; n < 32; n++) mux[n] = cand[n][w[2*n+:2]];
   endfunction : mux
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clk_sys);
      req <= '{1'b1, 1'b0, w, a, d};
      @(posedge clk_sys);
      req.penable <= 1'b1;
      i = 0;
      do @(posedge clk_sys); while (rsp.pready !== 1'b1 && ++i < 20);
      if (i >= 20) fails++;
      if (i >= 20) summarize();
      rd = rsp.prdata;
      er = rsp.pslverr;
      req <= '0;
   endtask : apb
   initial
   begin
      repeat (5) @(posedge clk_sys);
      nrst <= 1'b1;
      @(negedge clk_sys);
      chk(out, mux(0, 0));
      apb(0, SEL_LOW_ADDR, 0);
      chk(rd, SEL_WORD_RESET);
      apb(0, SEL_HIGH_ADDR, 0);
      chk(rd, SEL_WORD_RESET);
      apb(1, SEL_LOW_ADDR, 32'he4e4_e4e4);
      apb(1, SEL_HIGH_ADDR, 32'h1b1b_1b1b);
      apb(0, SEL_LOW_ADDR, 0);
      chk(rd, 32'he4e4_e4e4);
      apb(0, SEL_HIGH_ADDR, 0);
      chk(rd, 32'h1b1b_1b1b);
      chk(er, 0);
      @(negedge clk_sys);
      chk(out, mux(32'he4e4_e4e4, 32'h1b1b_1b1b));
      @(posedge clk_sys);
      cand <= ~cand;
      @(negedge clk_sys);
      chk(out, mux(32'he4e4_e4e4, 32'h1b1b_1b1b));
      apb(1, 8'h34, 32'hffff_ffff);
      chk(er, 1);
      apb(0, SEL_LOW_ADDR, 0);
      chk(rd, 32'he4e4_e4e4);
      summarize();
   end
endmodule : testbench
bind crossbar_output_select_regs xbar_out4_props props (.clk_sys(clk_sys), .nrst(nrst), .apb_req(apb_req),
   .apb_rsp(apb_rsp), .cand_in(cand_in), .crossbar_output_four(crossbar_output_four));
